/* File: core/isp_pkg.sv */
// Package for the I2C slave port: mode codes, field masks, reset values,
// bit counts and the carrier structs shared by the port and its user.
// Assumes the user logic sits on core_clk beside the port.
package isp_pkg;

    // ==========================================================
    // Mode codes held in port_mode_select
    // ==========================================================
    localparam logic [3:0] MODE_SLV7 = 4'h6;     // 7-bit slave
    localparam logic [3:0] MODE_SLV10 = 4'h7;    // 10-bit slave
    localparam logic [3:0] MODE_MASK = 4'h9;     // Mask register access
    localparam logic [3:0] MODE_FWIDLE = 4'hb;   // Firmware master, slave idle
    localparam logic [3:0] MODE_SLV7SP = 4'he;   // 7-bit slave, start/stop irq
    localparam logic [3:0] MODE_SLV10SP = 4'hf;  // 10-bit slave, start/stop irq

    // ==========================================================
    // Field layouts and reset values
    // ==========================================================
    localparam logic [7:0] MASK_RST = 8'hff;     // Full compare by default
    localparam logic [7:0] ADDR7_FIELD = 8'hfe;  // Bits 7..1 of a 7-bit address
    localparam logic [7:0] ADDR10_HI_FIELD = 8'h06; // A9..A8 in the header byte
    localparam logic [4:0] TEN_HDR = 5'h1e;      // Header pattern 11110
    localparam logic [3:0] BYTE_BITS = 4'h8;     // Data bits per byte
    localparam logic [3:0] ACK_BITS = 4'h9;      // Data bits plus acknowledge
    localparam int SCL_BIT = 0;                  // Direction bit of SCL
    localparam int SDA_BIT = 1;                  // Direction bit of SDA

    // Address stage of the current transfer
    typedef enum logic [1:0] {
        PH_FIRST = 2'b00,
        PH_SECOND = 2'b01,
        PH_DATA = 2'b10
    } isp_phase_e;

    // Software strobes and write data, one cycle each
    typedef struct packed {
        logic buf_rd;      // Read of shift_buffer_reg
        logic buf_wr;      // Write of shift_buffer_reg
        logic addr_wr;     // Write of own address or mask
        logic ckp_wr;      // Write of clock_release_bit
        logic ckp_val;     // Value written to clock_release_bit
        logic ov_clr;      // Clear receive_overflow_flag
        logic irq_clr;     // Clear port_interrupt_flag
        logic [7:0] wdata; // Write data for buffer and address
    } isp_sw_s;

    // Status seen by software
    typedef struct packed {
        logic buffer_full;
        logic overflow;
        logic read_not_write;
        logic data_not_addr;
        logic address_update;
        logic start_seen;
        logic stop_seen;
        logic irq;
        logic clock_release;
        logic bus_free;
    } isp_stat_s;

endpackage

/* File: core/isp_port.sv */
// I2C slave port: address match with mask, receive and transmit bytes,
// clock stretching, start/stop flags and firmware master pin control.
// Assumes SCL/SDA arrive raw from the pads, that scl_clk is the SCL pad
// wire used as a clock, and that software strobes are on core_clk.
`timescale 1ns/100ps

module isp_port (
    // Clocks and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic scl_clk,
    // Bus pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    // Software control
    input wire logic port_enable_bit,
    input wire logic [3:0] port_mode_select,
    input wire logic [1:0] pin_direction_bits,
    input wire isp_pkg::isp_sw_s sw,
    // Software read data and status
    output logic [7:0] buf_rdata,
    output logic [7:0] addr_rdata,
    output isp_pkg::isp_stat_s status
);

    // ==========================================================
    // Types and state
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,   // Wait for start
        ST_RECV = 3'b001,   // Shift a byte in
        ST_ACK = 3'b010,    // Ninth clock after a received byte
        ST_TX = 3'b011,     // Shift a byte out
        ST_TXACK = 3'b100,  // Master acknowledge of a sent byte
        ST_MON = 3'b101     // Firmware master byte count
    } isp_state_e;

    isp_state_e state_q, state_d;
    logic [7:0] link_sh;              // Link-side shift register
    logic [7:0] cap1_q, cap2_q;       // Byte crossing into core_clk
    logic scl_s1, scl_s2, scl_s3;     // SCL synchroniser and history
    logic sda_s1, sda_s2, sda_s3;     // SDA synchroniser and history
    logic [3:0] cnt_q;                // Rising edges since start of byte
    isp_pkg::isp_phase_e phase_q;     // Address stage
    logic [7:0] own_q, mask_q, buf_q; // Own address, mask, shift buffer
    logic bf_q, ov_q, rw_q, dna_q, ua_q, irq_q, ckp_q;
    logic start_q, stop_q, free_q;
    logic ten_q;                      // Ten-bit address already matched
    logic rdpend_q;                   // Read match waits for ninth fall
    logic ack_q;                      // Acknowledge to drive on ninth bit
    logic nack_q;                     // Master nack seen on ninth rise
    logic hold_q;                     // Slave stretches SCL
    logic ssda_q;                     // Slave pulls SDA low
    logic scl_oe_q, sda_oe_q, scl_out_q, sda_out_q;
    logic [7:0] addr_rd_q;

    // ==========================================================
    // Link domain: bits are sampled on SCL rising edges
    // ==========================================================
    // The link clock stops while SCL is low, so the byte stands still
    // until the core picks it up after the eighth falling edge.
    always_ff @(posedge scl_clk) begin
        link_sh <= {link_sh[6:0], sda_in};
    end

    // ==========================================================
    // Decode of events, modes and address compare
    // ==========================================================
    wire en = port_enable_bit;
    wire rise = scl_s2 & ~scl_s3;
    wire fall = ~scl_s2 & scl_s3;
    wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    wire mode10 = (port_mode_select == isp_pkg::MODE_SLV10)
        | (port_mode_select == isp_pkg::MODE_SLV10SP);
    wire mode7 = (port_mode_select == isp_pkg::MODE_SLV7)
        | (port_mode_select == isp_pkg::MODE_SLV7SP);
    wire slave_on = en & (mode7 | mode10);
    wire fw_idle = en & (port_mode_select == isp_pkg::MODE_FWIDLE);
    wire sp_irq = fw_idle | (port_mode_select == isp_pkg::MODE_SLV7SP)
        | (port_mode_select == isp_pkg::MODE_SLV10SP);
    wire fw_ok = en & sp_irq;
    wire mask_sel = port_mode_select == isp_pkg::MODE_MASK;
    wire [7:0] rx = cap2_q;
    wire [7:0] diff = (rx ^ own_q) & mask_q;
    wire m7 = (diff & isp_pkg::ADDR7_FIELD) == 8'h00;
    wire m10hi = (rx[7:3] == isp_pkg::TEN_HDR)
        & ((diff & isp_pkg::ADDR10_HI_FIELD) == 8'h00);
    wire m10lo = diff == 8'h00;
    wire first = phase_q == isp_pkg::PH_FIRST;
    wire hit = first ? (mode10 ? m10hi : m7)
        : (phase_q == isp_pkg::PH_SECOND) ? m10lo : 1'b1;
    wire byte_fall = fall & (cnt_q == isp_pkg::BYTE_BITS);
    wire nine_fall = fall & (cnt_q == isp_pkg::ACK_BITS);
    wire in_rx = byte_fall & (state_q == ST_RECV);
    wire rd_hit = hit & first & rx[0] & (mode7 | ten_q);
    wire wr_hit = hit & ~(first & rx[0]);
    wire blocked = bf_q | ov_q;
    wire load_rx = in_rx & ((wr_hit & ~blocked) | (rd_hit & ~bf_q));
    wire ov_set = in_rx & wr_hit & blocked;
    wire ack_go = (wr_hit & ~blocked) | rd_hit;
    wire is_addr = ~(phase_q == isp_pkg::PH_DATA);
    wire ua_set = in_rx & wr_hit & is_addr & mode10;
    wire tx8 = byte_fall & (state_q == ST_TX);
    wire rx9 = nine_fall & (state_q == ST_ACK);
    wire tx9 = nine_fall & (state_q == ST_TXACK);
    wire mon9 = nine_fall & (state_q == ST_MON);
    wire irq_set = rx9 | tx9 | mon9 | (fw_ok & (start_det | stop_det));
    wire ckp_hwclr = (rx9 & rdpend_q) | (tx9 & ~nack_q);
    wire want_hold = slave_on & (~ckp_q | ua_q);
    wire hold_d = want_hold & (hold_q | ~scl_s2);
    wire [2:0] bit_idx = ~cnt_q[2:0];
    wire tx_low = (state_q == ST_TX) & (cnt_q < isp_pkg::BYTE_BITS)
        & ~buf_q[bit_idx];
    wire want_sda = tx_low | ((state_q == ST_ACK) & ack_q);
    wire ssda_d = (state_q == ST_IDLE) ? 1'b0 : (scl_s2 ? ssda_q : want_sda);
    wire fw_scl = fw_ok & ~pin_direction_bits[isp_pkg::SCL_BIT];
    wire fw_sda = fw_ok & ~pin_direction_bits[isp_pkg::SDA_BIT];
    wire [7:0] addr_rd_d = mask_sel ? mask_q : own_q;

    // ==========================================================
    // Transfer state machine
    // ==========================================================
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                state_d = ST_IDLE;
            end
            ST_RECV: begin
                // A miss drops the transfer until the next start; a matched but
                // refused byte still runs its ninth clock so the irq is raised
                if (byte_fall) begin
                    state_d = (ack_go || ov_set) ? ST_ACK : ST_IDLE;
                end
            end
            ST_ACK: begin
                if (nine_fall) begin
                    state_d = rdpend_q ? ST_TX : ST_RECV;
                end
            end
            ST_TX: begin
                if (byte_fall) begin
                    state_d = ST_TXACK;
                end
            end
            ST_TXACK: begin
                // Nack ends the read, ack sends another byte
                if (nine_fall) begin
                    state_d = nack_q ? ST_IDLE : ST_TX;
                end
            end
            ST_MON: begin
                state_d = ST_MON;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Start and stop override any byte in progress
        if (!en || stop_det) begin
            state_d = ST_IDLE;
        end else if (start_det) begin
            state_d = slave_on ? ST_RECV : (fw_idle ? ST_MON : ST_IDLE);
        end
    end

    // ==========================================================
    // Pin synchronisers and byte capture
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (reset) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            cap1_q <= 8'h00;
            cap2_q <= 8'h00;
        end else if (clk_en) begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
            cap1_q <= link_sh;
            cap2_q <= cap1_q;
        end
    end

    // ==========================================================
    // Bit counter, state and address stage
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            phase_q <= isp_pkg::PH_FIRST;
        end else if (clk_en) begin
            state_q <= state_d;
            if (start_det || nine_fall) begin
                cnt_q <= 4'h0;
            end else if (rise) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (start_det) begin
                phase_q <= isp_pkg::PH_FIRST;
            end else if (in_rx && ack_go) begin
                phase_q <= (mode10 && first && !rx[0]) ? isp_pkg::PH_SECOND
                    : isp_pkg::PH_DATA;
            end
        end
    end

    // ==========================================================
    // Transfer bookkeeping: acknowledge, read request, ten-bit match
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdpend_q <= 1'b0;
            ten_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (clk_en) begin
            if (in_rx) begin
                ack_q <= ack_go;
                rdpend_q <= rd_hit;
            end
            if (!en || stop_det) begin
                ten_q <= 1'b0;
            end else if (in_rx && phase_q == isp_pkg::PH_SECOND && m10lo) begin
                ten_q <= 1'b1;
            end
            // Master acknowledge is sampled on the ninth rising edge
            if (rise && cnt_q == isp_pkg::BYTE_BITS && state_q == ST_TXACK) begin
                nack_q <= sda_s2;
            end
        end
    end

    // ==========================================================
    // Software-visible registers
    // ==========================================================
    // Hardware sets win over software clears in the same cycle so that
    // no event is lost.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            own_q <= 8'h00;
            mask_q <= isp_pkg::MASK_RST;
            buf_q <= 8'h00;
            bf_q <= 1'b0;
            ov_q <= 1'b0;
            rw_q <= 1'b0;
            dna_q <= 1'b0;
            ua_q <= 1'b0;
            irq_q <= 1'b0;
            ckp_q <= 1'b1;
        end else if (clk_en) begin
            if (sw.addr_wr && mask_sel) begin
                mask_q <= sw.wdata;
            end else if (sw.addr_wr) begin
                own_q <= sw.wdata;
            end
            // Received byte or software byte to send
            if (load_rx) begin
                buf_q <= rx;
            end else if (sw.buf_wr) begin
                buf_q <= sw.wdata;
            end
            if (load_rx || sw.buf_wr) begin
                bf_q <= 1'b1;
            end else if (sw.buf_rd || tx8) begin
                bf_q <= 1'b0;
            end
            if (ov_set) begin
                ov_q <= 1'b1;
            end else if (sw.ov_clr) begin
                ov_q <= 1'b0;
            end
            if (in_rx && (rd_hit || wr_hit)) begin
                rw_q <= rd_hit;
                dna_q <= ~is_addr;
            end
            if (ua_set) begin
                ua_q <= 1'b1;
            end else if (sw.addr_wr) begin
                ua_q <= 1'b0;
            end
            if (irq_set) begin
                irq_q <= 1'b1;
            end else if (sw.irq_clr) begin
                irq_q <= 1'b0;
            end
            if (sw.ckp_wr && sw.ckp_val) begin
                ckp_q <= 1'b1;
            end else if (ckp_hwclr) begin
                ckp_q <= 1'b0;
            end else if (sw.ckp_wr) begin
                ckp_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Start and stop flags
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (reset) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
            free_q <= 1'b1;
        end else if (clk_en) begin
            if (!en) begin
                start_q <= 1'b0;
                stop_q <= 1'b0;
            end else if (start_det) begin
                start_q <= 1'b1;
                stop_q <= 1'b0;
            end else if (stop_det) begin
                start_q <= 1'b0;
                stop_q <= 1'b1;
            end
            // Free one cycle after the flags settle
            free_q <= stop_q | (~start_q & ~stop_q);
        end
    end

    // ==========================================================
    // Pin drivers: outputs only ever pull low
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hold_q <= 1'b0;
            ssda_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_out_q <= 1'b0;
            sda_out_q <= 1'b0;
            addr_rd_q <= 8'h00;
        end else if (clk_en) begin
            hold_q <= hold_d;
            ssda_q <= ssda_d;
            scl_oe_q <= hold_d | fw_scl;
            sda_oe_q <= ssda_d | fw_sda;
            scl_out_q <= 1'b0;
            sda_out_q <= 1'b0;
            addr_rd_q <= addr_rd_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign scl_out = scl_out_q;
    assign sda_out = sda_out_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign buf_rdata = buf_q;
    assign addr_rdata = addr_rd_q;
    assign status = '{buffer_full: bf_q, overflow: ov_q, read_not_write: rw_q,
        data_not_addr: dna_q, address_update: ua_q, start_seen: start_q,
        stop_seen: stop_q, irq: irq_q, clock_release: ckp_q, bus_free: free_q};

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_mask_rst;
        $fell(reset) |-> mask_q == isp_pkg::MASK_RST;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask not all ones");

    property p_mask_lock;
        clk_en && sw.addr_wr && !mask_sel |=> $stable(mask_q);
    endproperty
    a_mask_lock: assert property (p_mask_lock) else $error("mask written");

    property p_load;
        clk_en && load_rx |=> bf_q && buf_q == $past(cap2_q);
    endproperty
    a_load: assert property (p_load) else $error("byte not loaded");

    property p_ovf;
        clk_en && in_rx && wr_hit && bf_q |=> ov_q && $stable(buf_q);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed");

    property p_noack;
        clk_en && in_rx && !rd_hit && blocked |=> !ack_q;
    endproperty
    a_noack: assert property (p_noack) else $error("acked when full");

    property p_rdhit;
        clk_en && in_rx && rd_hit |=> rw_q && state_q == ST_ACK;
    endproperty
    a_rdhit: assert property (p_rdhit) else $error("read not flagged");

    property p_stretch;
        clk_en && slave_on && !ckp_q && !scl_s2 |=> scl_oe_q;
    endproperty
    a_stretch: assert property (p_stretch) else $error("scl not held");

    property p_tx8;
        clk_en && tx8 && !sw.buf_wr |=> !bf_q ##0 state_q == ST_TXACK;
    endproperty
    a_tx8: assert property (p_tx8) else $error("full not cleared");

    property p_sda_rel;
        clk_en && tx8 && pin_direction_bits[isp_pkg::SDA_BIT] |=> !sda_oe_q;
    endproperty
    a_sda_rel: assert property (p_sda_rel) else $error("sda held");

    property p_start;
        clk_en && en && start_det |=> start_q && !stop_q;
    endproperty
    a_start: assert property (p_start) else $error("start flags");

    property p_dis;
        clk_en && !en |=> !start_q && !stop_q;
    endproperty
    a_dis: assert property (p_dis) else $error("flags not cleared");

    property p_fw_low;
        scl_oe_q || sda_oe_q |-> !scl_out && !sda_out;
    endproperty
    a_fw_low: assert property (p_fw_low) else $error("pin driven high");

endmodule // isp_port

/* File: dv/isp_master.sv */
// I2C bus master model for the slave port bench.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/100ps
module isp_master (
    // Link clock and wire levels
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda,
    // Pull-downs onto the wires
    output logic scl_pull,
    output logic sda_pull
);
    // ==========================================
    // Bit timing, five link clocks a half bit
    // ==========================================
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    task automatic hb();
        repeat (5) @(posedge link_clk);
    endtask
    // Let SCL go and wait out any stretch
    task automatic rise();
        scl_pull <= 1'b0;
        for (int n = 0; n < 9000 && scl !== 1'b1; n++) @(posedge link_clk);
        hb();
    endtask
    // One bit, MSB first; data moves only while SCL is low
    task automatic bt(input logic b, output logic r);
        sda_pull <= !b;
        hb();
        rise();
        r = sda;
        scl_pull <= 1'b1;
        hb();
    endtask
    task automatic start();
        sda_pull <= 1'b1;
        hb();
        scl_pull <= 1'b1;
        hb();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        hb();
        rise();
        sda_pull <= 1'b0;
        hb();
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, r);
        ack = !r;
    endtask
    task automatic rd(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        // Acknowledge slot: its sample must not overwrite the data
        bt(!ack, r);
    endtask
endmodule // isp_master

/* File: dv/isp_port_test.sv */
// Self-checking bench for the slave port: software strobes and a master model.
// Assumes the bus wires carry pull-ups.
`timescale 1ns/100ps
module isp_port_test;
    logic core_clk = 1'b0, link_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, port_enable_bit = 1'b1;
    logic [3:0] port_mode_select = isp_pkg::MODE_MASK;
    logic [1:0] pin_direction_bits = 2'h3;
    isp_pkg::isp_sw_s sw = '0;
    logic scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull, a;
    logic [7:0] buf_rdata, addr_rdata, d;
    isp_pkg::isp_stat_s status;
    int failures = 0, total_checks = 0;
    // Open drain with pull-ups
    wire scl = !(scl_pull || scl_oe);
    wire sda = !(sda_pull || sda_oe);
    always #10 core_clk = !core_clk;
    initial #7 forever #15 link_clk = !link_clk;
    isp_port dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .scl_clk(scl),
        .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .port_enable_bit(port_enable_bit), .port_mode_select(port_mode_select),
        .pin_direction_bits(pin_direction_bits), .sw(sw), .buf_rdata(buf_rdata),
        .addr_rdata(addr_rdata), .status(status));
    isp_master m_u (.link_clk(link_clk), .scl(scl), .sda(sda), .scl_pull(scl_pull),
        .sda_pull(sda_pull));
    // ==========================================
    // Tasks: strobes, settling, compare, verdict
    // ==========================================
    task automatic swp(input logic [6:0] s, input logic [7:0] w);
        @(posedge core_clk);
        sw <= {s, w};
        @(posedge core_clk);
        sw <= '0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic ck(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        results();
    end
    // Write with masked match, overflow, then a read
    initial begin
        settle(2);
        reset <= 1'b0;
        settle(4);
        ck(addr_rdata, isp_pkg::MASK_RST);
        swp(7'h10, 8'hfb);
        port_mode_select <= isp_pkg::MODE_SLV7;
        swp(7'h10, 8'h84);
        settle(3);
        ck(addr_rdata, 8'h84);
        m_u.start();
        m_u.wr(8'h80, a);
        settle(8);
        ck(a, 1);
        ck(buf_rdata, 8'h80);
        ck({status.buffer_full, status.data_not_addr, status.irq}, 5);
        ck({scl_out, sda_out}, 0);
        swp(7'h01, 8'h00);
        m_u.wr(8'h3c, a);
        settle(8);
        ck({a, status.overflow, buf_rdata}, 9'h180);
        ck(status.irq, 1);
        m_u.stop();
        settle(8);
        ck({status.stop_seen, status.start_seen, status.bus_free}, 5);
        swp(7'h43, 8'h00);
        m_u.start();
        settle(8);
        ck({status.start_seen, status.stop_seen}, 2);
        m_u.wr(8'h81, a);
        settle(8);
        ck({a, status.read_not_write, scl_oe}, 7);
        ck(status.clock_release, 0);
        swp(7'h41, 8'h00);
        swp(7'h20, 8'h5a);
        settle(1);
        ck(status.buffer_full, 1);
        swp(7'h0c, 8'h00);
        settle(2);
        ck(scl_oe, 0);
        m_u.rd(d, 1'b0);
        settle(8);
        ck(d, 8'h5a);
        ck({status.buffer_full, status.irq, sda_oe}, 2);
        m_u.stop();
        port_enable_bit <= 1'b0;
        settle(3);
        ck({status.stop_seen, status.start_seen}, 0);
        results();
    end
endmodule // isp_port_test
